// *** halfbridge_fault_supervisor_test.sv ***
module halfbridge_fault_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hbfs_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, rd = 1'b0, wr_s = 1'b0, smp = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, rdat, exp_v, msk_v;
  logic [NUM_BR-1:0] hs_on, ls_on, sh_hs = '0, sh_ls = '0, op_hs = '0, op_ls = '0;
  logic [NUM_BR-1:0] oc_hs, oc_ls, ol_hs, ol_ls;
  logic [1:0] ol_lt;
  logic [2:0] phase = '0;
  logic twarn = 1'b0, thermal_shutdown_flag = 1'b0, vlo = 1'b0, vhi = 1'b0, waitreq, irq;
  logic [31:0] exp_q[$], msk_q[$], act, on_exp;
  int miscompares = 0, n_checks = 0, b, c;
  always #4 clk_i = ~clk_i;
  hbfs_supervisor #(.OC_FILT_CYCLES(4), .OL_FILT_CYCLES(16), .LIGHT_FILT_CYCLES(8))
  u_hbfs_supervisor (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .pwm_phase_i(phase),
    .oc_hs_i(oc_hs), .oc_ls_i(oc_ls), .ol_hs_i(ol_hs), .ol_ls_i(ol_ls), .ol_light_hs_i(ol_lt),
    .temp_warn_i(twarn), .temp_sd_i(thermal_shutdown_flag), .vs_low_i(vlo), .vs_high_i(vhi),
    .hs_on_o(hs_on), .ls_on_o(ls_on), .irq_o(irq));
  hbfs_load_model u_hbfs_load_model (
    .hs_on_i(hs_on), .ls_on_i(ls_on), .short_hs_i(sh_hs), .short_ls_i(sh_ls),
    .open_hs_i(op_hs), .open_ls_i(op_ls), .oc_hs_o(oc_hs), .oc_ls_o(oc_ls),
    .ol_hs_o(ol_hs), .ol_ls_o(ol_ls), .ol_light_o(ol_lt));
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // One bus cycle; request held until the edge that samples waitrequest low.
  // A hung slave is caught by the watchdog, which ends the run through finish_test.
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    if (w) wr_s <= 1'b1; else rd <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr_s <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, '0);
  endtask : rdc
  // Samples {irq, high drives, low drives} at the next edge.
  task automatic chk_out(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    smp <= 1'b1;
    @(posedge clk_i);
    smp <= 1'b0;
    @(posedge clk_i);
  endtask : chk_out
  always @(posedge clk_i) begin
    if ((rd && waitreq === 1'b0) || smp) begin
      exp_v = exp_q.pop_front();
      msk_v = msk_q.pop_front();
      n_checks++;
      if (((smp ? {7'h0, irq, hs_on, ls_on} : rdat) & msk_v) !== exp_v) begin
        miscompares++;
        $display("ERROR %0t got %h expected %h", $time,
                 smp ? {7'h0, irq, hs_on, ls_on} : rdat, exp_v);
      end
    end
  end
  initial begin
    #(8 * 20000);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'hd0ce));
    b = $urandom % NUM_BR;
    c = (b + 1) % NUM_BR;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFS_ACT, 32'h0, 32'hFFFFFFFF);
    rdc(OFS_GSTAT, 32'h0, 32'hFFFFFFFF);
    rdc(6'h30, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, OFS_IRQ_MASK, 32'h1F);
    act = (32'h1 << b) | (32'h1 << (12 + c));
    bus(1'b1, OFS_ACT, act);
    chk_out((32'h1 << (12 + b)) | (32'h1 << c), 32'h1FFFFFF);
    sh_hs[b] <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk_out(32'h1000000 | (32'h1 << c), 32'h1FFFFFF);
    rdc(OFS_OC, 32'h1 << b, 32'hFFFFFF);
    rdc(OFS_GSTAT, 32'h40, 32'h40);
    rdc(OFS_ACT, act, 32'hFFFFFF);
    bus(1'b1, OFS_OC, 32'h1 << b);
    repeat (12) @(posedge clk_i);
    rdc(OFS_OC, 32'h1 << b, 32'hFFFFFF);
    sh_hs[b] <= 1'b0;
    bus(1'b1, OFS_OC, 32'h1 << b);
    repeat (3) @(posedge clk_i);
    rdc(OFS_IRQ_STAT, 32'h1, 32'h1);
    chk_out((32'h1 << (12 + b)) | (32'h1 << c), 32'h1FFFFFF);
    op_ls[c] <= 1'b1;
    repeat (25) @(posedge clk_i);
    rdc(OFS_OL, 32'h1 << (12 + c), 32'hFFFFFF);
    chk_out((32'h1 << (12 + b)) | (32'h1 << c), 32'hFFFFFF);
    op_ls[c] <= 1'b0;
    bus(1'b1, OFS_OL, 32'hFFFFFF);
    // The light-load filter must fire well before the normal one would.
    bus(1'b1, OFS_FWOL, 32'h1000);
    act = act | 32'h1;
    // An enabled high switch takes priority over the low switch of its own bridge.
    on_exp = {8'h00, act[11:0], act[23:12] & ~act[11:0]};
    bus(1'b1, OFS_ACT, act);
    op_hs[0] <= 1'b1;
    repeat (11) @(posedge clk_i);
    rdc(OFS_OL, 32'h1, 32'h1);
    op_hs[0] <= 1'b0;
    bus(1'b1, OFS_OL, 32'hFFFFFF);
    twarn <= 1'b1;
    repeat (2) @(posedge clk_i);
    twarn <= 1'b0;
    rdc(OFS_GSTAT, 32'h2, 32'h2);
    chk_out(on_exp, 32'hFFFFFF);
    thermal_shutdown_flag <= 1'b1;
    repeat (2) @(posedge clk_i);
    thermal_shutdown_flag <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_out(32'h0, 32'hFFFFFF);
    bus(1'b1, OFS_GSTAT, 32'h4);
    chk_out(on_exp, 32'hFFFFFF);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) vlo <= 1'b1; else vhi <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk_out(32'h0, 32'hFFFFFF);
      vlo <= 1'b0;
      vhi <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_out(on_exp, 32'hFFFFFF);
      rdc(OFS_GSTAT, k == 0 ? 32'h20 : 32'h10, k == 0 ? 32'h20 : 32'h10);
    end
    bus(1'b1, OFS_RATE, 32'h0);
    bus(1'b1, OFS_ASSIGN, 32'h1 << (2 * b));
    bus(1'b1, OFS_ACT, 32'h1 << b);
    bus(1'b1, OFS_FWOL, 32'h1 << b);
    phase <= 3'($urandom);
    repeat (3) @(posedge clk_i);
    chk_out(32'h1 << b, 32'hFFFFFF);
    op_ls[b] <= 1'b1;
    repeat (25) @(posedge clk_i);
    rdc(OFS_OL, 32'h0, 32'hFFFFFF);
    bus(1'b1, OFS_RATE, 32'h1);
    phase <= 3'h1;
    repeat (3) @(posedge clk_i);
    chk_out(32'h1 << (12 + b), 32'hFFFFFF);
    phase <= 3'h0;
    repeat (3) @(posedge clk_i);
    chk_out(32'h1 << b, 32'hFFFFFF);
    finish_test();
  end
endmodule : halfbridge_fault_supervisor_test

// *** hbfs_filter.sv ***
module hbfs_filter #(
  parameter int W = hbfs_pkg::CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         cond_i,
  input  wire logic [W-1:0] limit_i,
  output logic              hit_o
);
  import hbfs_pkg::*;

  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         hit_q;
  logic         hit_d;

  // The count saturates, so a condition held forever keeps the hit asserted.
  always_comb begin
    cnt_d = '0;
    hit_d = 1'h0;
    if (cond_i) begin
      cnt_d = (cnt_q >= limit_i) ? cnt_q : cnt_q + ONE;
      hit_d = (cnt_q + ONE) >= limit_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      hit_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule : hbfs_filter

// *** hbfs_load_model.sv ***
module hbfs_load_model
  import hbfs_pkg::*;
(
  input  wire logic [hbfs_pkg::NUM_BR-1:0] hs_on_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0] ls_on_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0] short_hs_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0] short_ls_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0] open_hs_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0] open_ls_i,
  output logic      [hbfs_pkg::NUM_BR-1:0] oc_hs_o,
  output logic      [hbfs_pkg::NUM_BR-1:0] oc_ls_o,
  output logic      [hbfs_pkg::NUM_BR-1:0] ol_hs_o,
  output logic      [hbfs_pkg::NUM_BR-1:0] ol_ls_o,
  output logic      [1:0]                  ol_light_o
);
  // A short only draws current while its own switch conducts, so a released stage reads clean.
  assign oc_hs_o    = hs_on_i & short_hs_i;
  assign oc_ls_o    = ls_on_i & short_ls_i;
  assign ol_hs_o    = hs_on_i & open_hs_i;
  assign ol_ls_o    = ls_on_i & open_ls_i;
  assign ol_light_o = hs_on_i[1:0] & open_hs_i[1:0];
endmodule : hbfs_load_model

// *** hbfs_pkg.sv ***
package hbfs_pkg;

  localparam int NUM_BR = 12;
  localparam int NSW    = 2 * NUM_BR;
  localparam int ADDR_W = 6;
  localparam int CNT_W  = 20;
  localparam int RATE_W = 6;
  localparam int FWOL_W = 14;
  localparam int IRQ_W  = 5;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int OC_FILT_NS     = 10000;
  localparam int OL_FILT_NS     = 200000;
  localparam int LIGHT_FILT_NS  = 100000;
  localparam int OC_FILT_CYC    = (OC_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OL_FILT_CYC    = (OL_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LIGHT_FILT_CYC = (LIGHT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [ADDR_W-1:0] OFS_GSTAT    = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OC       = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OL       = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ACT      = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN   = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_RATE     = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FWOL     = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h20;

  localparam int GST_WARN = 1;
  localparam int GST_TSD  = 2;
  localparam int GST_VH   = 4;
  localparam int GST_VL   = 5;
  localparam int GST_LOAD = 6;

  localparam int FWOL_LIGHT0 = 12;
  localparam int FWOL_LIGHT1 = 13;

  localparam int IRQ_LOAD = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_TSD  = 2;
  localparam int IRQ_VH   = 3;
  localparam int IRQ_VL   = 4;

  localparam logic [1:0] RATE_STOP = 2'h0;
  localparam logic [1:0] CH_NONE   = 2'h0;

  localparam logic [NSW-1:0]    RST_CFG  = 24'h000000;
  localparam logic [RATE_W-1:0] RST_RATE = 6'h00;
  localparam logic [FWOL_W-1:0] RST_FWOL = 14'h0000;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 5'h00;

  typedef enum logic {
    BUS_IDLE = 1'h0,
    BUS_ACK  = 1'h1
  } hbfs_bus_e;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

endpackage : hbfs_pkg

// *** hbfs_supervisor.sv ***
module hbfs_supervisor #(
  parameter int unsigned OC_FILT_CYCLES    = hbfs_pkg::OC_FILT_CYC,
  parameter int unsigned OL_FILT_CYCLES    = hbfs_pkg::OL_FILT_CYC,
  parameter int unsigned LIGHT_FILT_CYCLES = hbfs_pkg::LIGHT_FILT_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [hbfs_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [31:0]                  avs_readdata_o,
  output logic                              avs_waitrequest_o,
  input  wire logic [2:0]                   pwm_phase_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0]  oc_hs_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0]  oc_ls_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0]  ol_hs_i,
  input  wire logic [hbfs_pkg::NUM_BR-1:0]  ol_ls_i,
  input  wire logic [1:0]                   ol_light_hs_i,
  input  wire logic                         temp_warn_i,
  input  wire logic                         temp_sd_i,
  input  wire logic                         vs_low_i,
  input  wire logic                         vs_high_i,
  output logic      [hbfs_pkg::NUM_BR-1:0]  hs_on_o,
  output logic      [hbfs_pkg::NUM_BR-1:0]  ls_on_o,
  output logic                              irq_o
);
  import hbfs_pkg::*;

  hbfs_bus_e         state_q;
  hbfs_bus_e         state_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [31:0]       rd_word;
  logic [31:0]       wmask;
  logic [31:0]       gclr;
  logic              acc;
  logic              wr_acc;
  logic              rd_acc;

  logic [NSW-1:0]    bridge_activation_config_q;
  logic [NSW-1:0]    bridge_activation_config_d;
  logic [NSW-1:0]    bridge_channel_assign_q;
  logic [NSW-1:0]    bridge_channel_assign_d;
  logic [RATE_W-1:0] pwm_channel_rate_config_q;
  logic [RATE_W-1:0] pwm_channel_rate_config_d;
  logic [FWOL_W-1:0] freewheel_openload_config_q;
  logic [FWOL_W-1:0] freewheel_openload_config_d;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_mask_d;
  logic [IRQ_W-1:0]  irq_evt;
  logic [IRQ_W-1:0]  irq_rdclr;
  logic              irq_q;
  logic              irq_d;

  logic              thermal_warning_flag_q;
  logic              thermal_warning_flag_d;
  logic              thermal_shutdown_flag_q;
  logic              thermal_shutdown_flag_d;
  logic              supply_low_flag_q;
  logic              supply_low_flag_d;
  logic              supply_high_flag_q;
  logic              supply_high_flag_d;
  logic              load_fault_summary_q;
  logic              load_fault_summary_d;
  logic [NSW-1:0]    oc_q;
  logic [NSW-1:0]    oc_d;
  logic [NSW-1:0]    ol_q;
  logic [NSW-1:0]    ol_d;
  logic [NSW-1:0]    oc_hit;
  logic [NSW-1:0]    ol_hit;
  logic [NSW-1:0]    oc_cond;
  logic [NSW-1:0]    ol_cond;
  logic [NSW-1:0]    oc_clr;
  logic [NSW-1:0]    ol_clr;
  logic [NSW-1:0]    on_q;

  logic [NUM_BR-1:0] hs_on_q;
  logic [NUM_BR-1:0] hs_on_d;
  logic [NUM_BR-1:0] ls_on_q;
  logic [NUM_BR-1:0] ls_on_d;
  logic [NUM_BR-1:0] fw_stop;
  logic [NUM_BR-1:0] ol_blank;
  logic [NUM_BR-1:0] hs_en;
  logic [NUM_BR-1:0] ls_en;
  logic [NUM_BR-1:0] fw_active;
  logic              light_load_select_first;
  logic              light_load_select_second;
  logic              glob_off;
  logic [1:0]        ch;
  logic [7:0]        rate_ext;
  logic [3:0]        phase_ext;
  logic              run;
  logic              ph;
  logic              hw;
  logic              lw;

  function automatic logic [31:0] upd(input logic [31:0] q,
                                      input logic [31:0] wd,
                                      input logic [31:0] m);
    return (q & ~m) | (wd & m);
  endfunction : upd

  assign hs_en                    = bridge_activation_config_q[NUM_BR-1:0];
  assign ls_en                    = bridge_activation_config_q[NSW-1:NUM_BR];
  assign fw_active                = freewheel_openload_config_q[NUM_BR-1:0];
  assign light_load_select_first  = freewheel_openload_config_q[FWOL_LIGHT0];
  assign light_load_select_second = freewheel_openload_config_q[FWOL_LIGHT1];
  assign on_q                     = {ls_on_q, hs_on_q};
  assign glob_off                 = thermal_shutdown_flag_q | vs_low_i | vs_high_i;

  // One wait cycle lets read data come from a flop while still meeting the bus timing.
  assign acc               = state_q == BUS_ACK;
  assign wr_acc            = acc & avs_write_i;
  assign rd_acc            = acc & avs_read_i;
  assign wmask             = be_mask(avs_byteenable_i);
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc;
  assign avs_readdata_o    = rdata_q;

  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address_i)
      OFS_GSTAT: begin
        rd_word[GST_WARN] = thermal_warning_flag_q;
        rd_word[GST_TSD]  = thermal_shutdown_flag_q;
        rd_word[GST_VH]   = supply_high_flag_q;
        rd_word[GST_VL]   = supply_low_flag_q;
        rd_word[GST_LOAD] = load_fault_summary_q;
      end
      OFS_OC:       rd_word = {8'h00, oc_q};
      OFS_OL:       rd_word = {8'h00, ol_q};
      OFS_ACT:      rd_word = {8'h00, bridge_activation_config_q};
      OFS_ASSIGN:   rd_word = {8'h00, bridge_channel_assign_q};
      OFS_RATE:     rd_word = {26'h0000000, pwm_channel_rate_config_q};
      OFS_FWOL:     rd_word = {18'h00000, freewheel_openload_config_q};
      OFS_IRQ_STAT: rd_word = {27'h0000000, irq_stat_q};
      OFS_IRQ_MASK: rd_word = {27'h0000000, irq_mask_q};
      default:      rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    case (state_q)
      BUS_IDLE: begin
        if (avs_read_i | avs_write_i) begin
          state_d = BUS_ACK;
          rdata_d = avs_read_i ? rd_word : 32'h00000000;
        end
      end
      BUS_ACK:  state_d = BUS_IDLE;
      default:  state_d = BUS_IDLE;
    endcase
  end

  always_comb begin
    bridge_activation_config_d  = bridge_activation_config_q;
    bridge_channel_assign_d     = bridge_channel_assign_q;
    pwm_channel_rate_config_d   = pwm_channel_rate_config_q;
    freewheel_openload_config_d = freewheel_openload_config_q;
    irq_mask_d                  = irq_mask_q;
    if (wr_acc) begin
      case (avs_address_i)
        OFS_ACT: bridge_activation_config_d =
            NSW'(upd({8'h00, bridge_activation_config_q}, avs_writedata_i, wmask));
        OFS_ASSIGN: bridge_channel_assign_d =
            NSW'(upd({8'h00, bridge_channel_assign_q}, avs_writedata_i, wmask));
        OFS_RATE: pwm_channel_rate_config_d =
            RATE_W'(upd({26'h0000000, pwm_channel_rate_config_q}, avs_writedata_i, wmask));
        OFS_FWOL: freewheel_openload_config_d =
            FWOL_W'(upd({18'h00000, freewheel_openload_config_q}, avs_writedata_i, wmask));
        OFS_IRQ_MASK: irq_mask_d =
            IRQ_W'(upd({27'h0000000, irq_mask_q}, avs_writedata_i, wmask));
        default: irq_mask_d = irq_mask_q;
      endcase
    end
  end

  // Hardware sets win over a clear in the same cycle, so a live fault is never lost.
  always_comb begin
    gclr   = (wr_acc && avs_address_i == OFS_GSTAT) ? (avs_writedata_i & wmask) : 32'h00000000;
    oc_clr = (wr_acc && avs_address_i == OFS_OC) ? NSW'(avs_writedata_i & wmask) : '0;
    ol_clr = (wr_acc && avs_address_i == OFS_OL) ? NSW'(avs_writedata_i & wmask) : '0;
    oc_d   = (oc_q & ~oc_clr) | oc_hit;
    ol_d   = (ol_q & ~ol_clr) | ol_hit;
    load_fault_summary_d    = (load_fault_summary_q & ~gclr[GST_LOAD]) | (|oc_hit) | (|ol_hit);
    thermal_warning_flag_d  = (thermal_warning_flag_q & ~gclr[GST_WARN]) | temp_warn_i;
    thermal_shutdown_flag_d = (thermal_shutdown_flag_q & ~gclr[GST_TSD]) | temp_sd_i;
    supply_high_flag_d      = (supply_high_flag_q & ~gclr[GST_VH]) | vs_high_i;
    supply_low_flag_d       = (supply_low_flag_q & ~gclr[GST_VL]) | vs_low_i;
    irq_evt           = '0;
    irq_evt[IRQ_LOAD] = |((oc_d & ~oc_q) | (ol_d & ~ol_q));
    irq_evt[IRQ_WARN] = thermal_warning_flag_d & ~thermal_warning_flag_q;
    irq_evt[IRQ_TSD]  = thermal_shutdown_flag_d & ~thermal_shutdown_flag_q;
    irq_evt[IRQ_VH]   = supply_high_flag_d & ~supply_high_flag_q;
    irq_evt[IRQ_VL]   = supply_low_flag_d & ~supply_low_flag_q;
    // Only the bits actually returned to software are cleared by the read.
    irq_rdclr  = (rd_acc && avs_address_i == OFS_IRQ_STAT) ? rdata_q[IRQ_W-1:0] : '0;
    irq_stat_d = (irq_stat_q & ~irq_rdclr) | irq_evt;
    irq_d      = |(irq_stat_q & irq_mask_q);
  end

  // Current flows only through a driven switch, so detection is qualified by the drive.
  always_comb begin
    oc_cond    = {oc_ls_i, oc_hs_i} & on_q;
    ol_cond    = {ol_ls_i, ol_hs_i};
    ol_cond[0] = light_load_select_first ? ol_light_hs_i[0] : ol_hs_i[0];
    ol_cond[1] = light_load_select_second ? ol_light_hs_i[1] : ol_hs_i[1];
    ol_cond    = ol_cond & on_q & ~{ol_blank, ol_blank};
  end

  for (genvar g = 0; g < NSW; g++) begin : g_filt
    logic [CNT_W-1:0] ol_lim;
    if (g < 2) begin : g_light
      assign ol_lim = freewheel_openload_config_q[FWOL_LIGHT0 + g] ?
                      CNT_W'(LIGHT_FILT_CYCLES) : CNT_W'(OL_FILT_CYCLES);
    end else begin : g_norm
      assign ol_lim = CNT_W'(OL_FILT_CYCLES);
    end
    hbfs_filter #(.W(CNT_W)) u_oc (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .cond_i    (oc_cond[g]),
      .limit_i   (CNT_W'(OC_FILT_CYCLES)),
      .hit_o     (oc_hit[g])
    );
    hbfs_filter #(.W(CNT_W)) u_ol (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .cond_i    (ol_cond[g]),
      .limit_i   (ol_lim),
      .hit_o     (ol_hit[g])
    );
  end

  // Both switches of one bridge are never driven together; high side takes priority.
  always_comb begin
    hs_on_d   = '0;
    ls_on_d   = '0;
    fw_stop   = '0;
    ol_blank  = '0;
    ch        = CH_NONE;
    run       = 1'h0;
    ph        = 1'h0;
    hw        = 1'h0;
    lw        = 1'h0;
    rate_ext  = {pwm_channel_rate_config_q, RATE_STOP};
    phase_ext = {pwm_phase_i, 1'h0};
    for (int i = 0; i < NUM_BR; i++) begin
      ch  = bridge_channel_assign_q[2*i +: 2];
      run = rate_ext[{ch, 1'h0} +: 2] != RATE_STOP;
      ph  = phase_ext[ch];
      hw  = 1'h0;
      lw  = 1'h0;
      if (ch == CH_NONE) begin
        hw = hs_en[i];
        lw = ls_en[i] & ~hs_en[i];
      end else if (hs_en[i]) begin
        hw = run & ph;
        lw = fw_active[i] & ~(run & ph);
        fw_stop[i] = fw_active[i] & ~run;
      end else if (ls_en[i]) begin
        lw = run & ph;
        hw = fw_active[i] & ~(run & ph);
      end
      ol_blank[i] = (ch != CH_NONE) & fw_active[i];
      hs_on_d[i] = hw & ~oc_q[i] & ~glob_off;
      ls_on_d[i] = lw & ~oc_q[NUM_BR + i] & ~glob_off;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q                     <= BUS_IDLE;
      rdata_q                     <= 32'h00000000;
      bridge_activation_config_q  <= RST_CFG;
      bridge_channel_assign_q     <= RST_CFG;
      pwm_channel_rate_config_q   <= RST_RATE;
      freewheel_openload_config_q <= RST_FWOL;
      irq_stat_q                  <= RST_IRQ;
      irq_mask_q                  <= RST_IRQ;
      irq_q                       <= 1'h0;
      thermal_warning_flag_q      <= 1'h0;
      thermal_shutdown_flag_q     <= 1'h0;
      supply_low_flag_q           <= 1'h0;
      supply_high_flag_q          <= 1'h0;
      load_fault_summary_q        <= 1'h0;
      oc_q                        <= '0;
      ol_q                        <= '0;
      hs_on_q                     <= '0;
      ls_on_q                     <= '0;
    end else begin
      state_q                     <= state_d;
      rdata_q                     <= rdata_d;
      bridge_activation_config_q  <= bridge_activation_config_d;
      bridge_channel_assign_q     <= bridge_channel_assign_d;
      pwm_channel_rate_config_q   <= pwm_channel_rate_config_d;
      freewheel_openload_config_q <= freewheel_openload_config_d;
      irq_stat_q                  <= irq_stat_d;
      irq_mask_q                  <= irq_mask_d;
      irq_q                       <= irq_d;
      thermal_warning_flag_q      <= thermal_warning_flag_d;
      thermal_shutdown_flag_q     <= thermal_shutdown_flag_d;
      supply_low_flag_q           <= supply_low_flag_d;
      supply_high_flag_q          <= supply_high_flag_d;
      load_fault_summary_q        <= load_fault_summary_d;
      oc_q                        <= oc_d;
      ol_q                        <= ol_d;
      hs_on_q                     <= hs_on_d;
      ls_on_q                     <= ls_on_d;
    end
  end

  assign hs_on_o = hs_on_q;
  assign ls_on_o = ls_on_q;
  assign irq_o   = irq_q;

  a_tsd_all_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    thermal_shutdown_flag_q |=> (hs_on_o == '0 && ls_on_o == '0))
    else $error("outputs driven during thermal shutdown");

  a_supply_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (vs_low_i || vs_high_i) |=> (hs_on_o == '0 && ls_on_o == '0))
    else $error("outputs driven during supply fault");

  a_low_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    vs_low_i |=> supply_low_flag_q)
    else $error("supply low flag not latched");

  a_high_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(vs_high_i) |=> supply_high_flag_q ##1 (supply_high_flag_q || !$past(vs_high_i)))
    else $error("supply high flag not latched");

  a_warn_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (temp_warn_i && !wr_acc) |=> thermal_warning_flag_q)
    else $error("warning flag not latched");

  a_oc_keeps_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'h1 |=> ((hs_on_o & $past(oc_q[NUM_BR-1:0])) == '0))
    else $error("high switch driven while overcurrent bit set");

  a_oc_act_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (|oc_hit && !wr_acc) |=> $stable(bridge_activation_config_q))
    else $error("activation bits changed by overcurrent");

  a_load_summary: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (|oc_hit || |ol_hit) |=> load_fault_summary_q &&
                             (avs_address_i != OFS_GSTAT || rd_word[GST_LOAD]))
    else $error("load summary not set on load fault");

  a_fw_stop_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'h1 |=> ((hs_on_o & $past(fw_stop)) == '0))
    else $error("high switch driven while stopped free-wheel");

  a_bus_one_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held longer than one cycle");

endmodule : hbfs_supervisor
